/* logic/mums_pkg.sv */
package mums_pkg;

  // Processor bus geometry
  localparam int          ADDR_W          = 13;
  localparam logic [7:0]  SOFT_INT_OPCODE = 8'h83;
  localparam logic [7:0]  RET_INT_OPCODE  = 8'h80;

  // Monitor map is a 4K window repeated through the address space
  localparam logic [12:0] MON_ADDR_MASK   = 13'h0FFF;

  // User map regions
  localparam logic [12:0] USER_IO_HI      = 13'h000F;
  localparam logic [12:0] USER_RAM_LO     = 13'h0010;
  localparam logic [12:0] USER_RAM_HI     = 13'h007F;
  localparam logic [12:0] USER_PROG_LO    = 13'h0080;
  localparam logic [12:0] USER_PROG_HI    = 13'h0FFF;
  localparam logic [12:0] USER_2K_MASK    = 13'h07FF;

  // Sequence counts
  localparam logic [2:0]  TEMP_OPERANDS   = 3'h2;
  localparam logic [2:0]  STACK_BYTES     = 3'h5;
  localparam logic [2:0]  CNT_RESET       = 3'h0;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  localparam logic [12:0] ADDR_RESET      = 13'h0000;

  // Pin synchroniser lanes
  localparam int          PIN_N           = 3;
  localparam int          PIN_USER_RESET  = 0;
  localparam int          PIN_ABORT       = 1;
  localparam int          PIN_MAP_2K      = 2;

  typedef logic [ADDR_W-1:0] mums_addr_t;

  typedef enum logic [2:0] {
    ST_MON,
    ST_TEMP_FETCH,
    ST_TEMP_USER,
    ST_PERM_WAIT,
    ST_USER,
    ST_USER_RST,
    ST_ABORT_FORCE,
    ST_STACK
  } mums_state_t;

  // Registered chip selects for one bus cycle
  typedef struct packed {
    logic valid;
    logic mon_sel;
    logic user_io_sel;
    logic user_ram_sel;
    logic user_prog_sel;
    logic write_block;
  } mums_decode_t;

endpackage : mums_pkg

/* logic/mums_map_switch.sv */
`timescale 1ns/1ps
// Operation
// - Exactly one map, monitor or user, active.
// - Temporary switch: fetch three bytes, then user.
// - Next opcode fetch returns to monitor map.
// - Permanent switch by command or user reset.
// - Return opcode from monitor, then user map.
// - User reset resets core, selects user map.
// - Breakpoints ignored after user reset entry.
// - Soft interrupt with breakpoint or abort returns.
// - Plain soft interrupt stays in user map.
// - Abort forces soft interrupt until opcode fetch.
// - Abort does nothing in monitor map.
// - Five stacked bytes precede monitor re-entry.
// - User RAM and stack at 010-07F.
// - Program space write protected while running.
// - 2K option mirrors lower 2K upward.
module mums_map_switch
  import mums_pkg::*;
(
  input  wire logic         CLK_IN,
  input  wire logic         RST_IN,
  input  wire logic         BUS_VALID_IN,
  input  wire mums_addr_t   BUS_ADDR_IN,
  input  wire logic         BUS_WR_IN,
  input  wire logic         OPCODE_FETCH_CYCLE_IN,
  input  wire logic [7:0]   BUS_DATA_IN,
  input  wire logic         TEMP_SWITCH_CMD_IN,
  input  wire logic         PERM_SWITCH_CMD_IN,
  input  wire logic         BKPT_SET_IN,
  input  wire logic         BKPT_CLEAR_IN,
  input  wire logic         USER_RESET_SW_IN,
  input  wire logic         ABORT_SW_IN,
  input  wire logic         MAP_2K_SEL_IN,
  output logic              USER_MAP_OUT,
  output mums_decode_t      DECODE_OUT,
  output mums_addr_t        MAPPED_ADDR_OUT,
  output logic              FORCE_DATA_OE_OUT,
  output logic [7:0]        FORCE_DATA_OUT,
  output logic              USER_RESET_OUT,
  output logic              USER_RESET_MODE_OUT,
  output logic              BKPT_ARMED_OUT
);

  mums_state_t      state;
  mums_state_t      next_state;
  logic [2:0]       cnt;
  logic [PIN_N-1:0] pin_meta;
  logic [PIN_N-1:0] pin_sync;
  logic             user_rst_prev;
  logic             user_rst_rise;
  logic             abort_held;
  logic             map_2k;
  logic             bkpt;
  logic             fetch;
  logic             swi_seen;
  logic             temp_return;
  logic             dec_user;
  mums_addr_t       user_addr;

  // User map states; one encoding per map keeps the maps exclusive
  function automatic logic is_user(input mums_state_t s);
    return (s == ST_TEMP_USER) || (s == ST_USER) || (s == ST_USER_RST) ||
           (s == ST_ABORT_FORCE) || (s == ST_STACK);
  endfunction : is_user

  // Program space is locked only while user code is running
  function automatic logic is_running(input mums_state_t s);
    return (s == ST_USER) || (s == ST_USER_RST) || (s == ST_ABORT_FORCE) || (s == ST_STACK);
  endfunction : is_running

  // Address decode for one bus cycle
  function automatic mums_decode_t decode_fn(input mums_addr_t a, input logic user,
                                             input logic lock, input logic wr);
    mums_decode_t d;
    d = '0;
    d.valid = 1'b1;
    if (!user) begin
      d.mon_sel = 1'b1;
    end else if (a <= USER_IO_HI) begin
      d.user_io_sel = 1'b1;
    end else if (a <= USER_RAM_HI) begin
      d.user_ram_sel = 1'b1;
    end else begin
      d.user_prog_sel = 1'b1;
      d.write_block   = lock & wr;
    end
    return d;
  endfunction : decode_fn

  // Switches and jumper come from pins; two flops before any use
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {MAP_2K_SEL_IN, ABORT_SW_IN, USER_RESET_SW_IN};
      pin_sync <= pin_meta;
    end
  end

  // Edge memory for the user reset switch
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      user_rst_prev <= 1'b0;
    end else begin
      user_rst_prev <= pin_sync[PIN_USER_RESET];
    end
  end

  assign user_rst_rise = pin_sync[PIN_USER_RESET] & ~user_rst_prev;
  assign abort_held    = pin_sync[PIN_ABORT];
  assign map_2k        = pin_sync[PIN_MAP_2K];
  assign fetch         = BUS_VALID_IN & OPCODE_FETCH_CYCLE_IN;
  assign swi_seen      = fetch & (BUS_DATA_IN == SOFT_INT_OPCODE);

  // The fetch that ends a temporary switch must already be served by the monitor
  assign temp_return   = (state == ST_TEMP_USER) & fetch;
  assign dec_user      = is_user(state) & ~temp_return;
  // 2K option folds the upper 6K onto the lower 2K before any region is decoded
  assign user_addr     = map_2k ? (BUS_ADDR_IN & USER_2K_MASK) : BUS_ADDR_IN;

  // Breakpoint flip-flop; a set in the clearing cycle wins
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bkpt <= 1'b0;
    end else if (BKPT_SET_IN) begin
      bkpt <= 1'b1;
    end else if (BKPT_CLEAR_IN) begin
      bkpt <= 1'b0;
    end
  end

  // Map sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ST_MON: begin
        // Abort is not looked at here, so it cannot disturb the monitor
        if (TEMP_SWITCH_CMD_IN) begin
          next_state = ST_TEMP_FETCH;
        end else if (PERM_SWITCH_CMD_IN) begin
          next_state = ST_PERM_WAIT;
        end
      end
      ST_TEMP_FETCH: begin
        // Opcode plus two operands come from the monitor first
        if (BUS_VALID_IN && (fetch || cnt != CNT_RESET) && cnt == TEMP_OPERANDS) begin
          next_state = ST_TEMP_USER;
        end
      end
      ST_TEMP_USER: begin
        if (fetch) begin
          next_state = ST_MON;
        end
      end
      ST_PERM_WAIT: begin
        if (fetch && BUS_DATA_IN == RET_INT_OPCODE) begin
          next_state = ST_USER;
        end
      end
      ST_USER, ST_USER_RST: begin
        // Breakpoint only counts when entered by monitor command
        if (swi_seen && ((bkpt && state == ST_USER) || abort_held)) begin
          next_state = ST_STACK;
        end else if (abort_held) begin
          next_state = ST_ABORT_FORCE;
        end
        // Any other soft interrupt runs in user space
      end
      ST_ABORT_FORCE: begin
        if (fetch) begin
          next_state = ST_STACK;
        end
      end
      ST_STACK: begin
        // Vector fetch after the last push comes from the monitor
        if (BUS_VALID_IN && BUS_WR_IN && cnt == STACK_BYTES - 3'h1) begin
          next_state = ST_MON;
        end
      end
    endcase
    if (user_rst_rise) begin
      next_state = ST_USER_RST;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= ST_MON;
    end else begin
      state <= next_state;
    end
  end

  // Byte counter for the temporary fetch and the register stacking
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cnt <= CNT_RESET;
    end else if (next_state != state) begin
      cnt <= CNT_RESET;
    end else if (state == ST_TEMP_FETCH && BUS_VALID_IN && (fetch || cnt != CNT_RESET)) begin
      cnt <= cnt + 3'h1;
    end else if (state == ST_STACK && BUS_VALID_IN && BUS_WR_IN) begin
      cnt <= cnt + 3'h1;
    end
  end

  // Map flag and forced opcode follow the next state so they align with it
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      USER_MAP_OUT      <= 1'b0;
      FORCE_DATA_OE_OUT <= 1'b0;
      FORCE_DATA_OUT    <= DATA_RESET;
    end else begin
      USER_MAP_OUT      <= is_user(next_state);
      FORCE_DATA_OE_OUT <= (next_state == ST_ABORT_FORCE);
      FORCE_DATA_OUT    <= (next_state == ST_ABORT_FORCE) ? SOFT_INT_OPCODE : DATA_RESET;
    end
  end

  // Status and the core/user I/O reset, held while the switch is down
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      USER_RESET_OUT      <= 1'b0;
      USER_RESET_MODE_OUT <= 1'b0;
      BKPT_ARMED_OUT      <= 1'b0;
    end else begin
      USER_RESET_OUT      <= pin_sync[PIN_USER_RESET];
      USER_RESET_MODE_OUT <= (next_state == ST_USER_RST);
      BKPT_ARMED_OUT      <= bkpt;
    end
  end

  // Selects are registered, so they lag the bus cycle by one clock
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      DECODE_OUT      <= '0;
      MAPPED_ADDR_OUT <= ADDR_RESET;
    end else if (BUS_VALID_IN) begin
      DECODE_OUT <= decode_fn(user_addr, dec_user, is_running(state), BUS_WR_IN);
      if (!dec_user) begin
        MAPPED_ADDR_OUT <= BUS_ADDR_IN & MON_ADDR_MASK;
      end else begin
        MAPPED_ADDR_OUT <= user_addr;
      end
    end else begin
      DECODE_OUT <= '0;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  property p_one_map;
    BUS_VALID_IN |=> DECODE_OUT.valid && (DECODE_OUT.mon_sel == (!$past(USER_MAP_OUT) || $past(temp_return))) &&
      $onehot({DECODE_OUT.mon_sel, DECODE_OUT.user_io_sel, DECODE_OUT.user_ram_sel, DECODE_OUT.user_prog_sel});
  endproperty
  a_one_map: assert property (p_one_map) else $error("map selects not exclusive");

  property p_temp_first_fetch;
    (state == ST_TEMP_FETCH) && fetch && cnt == CNT_RESET && !user_rst_rise |=> !USER_MAP_OUT ##1 !USER_MAP_OUT;
  endproperty
  a_temp_first_fetch: assert property (p_temp_first_fetch) else $error("temp switch left monitor early");

  property p_temp_after_three;
    $rose(state == ST_TEMP_USER) |-> $past(cnt) == TEMP_OPERANDS && USER_MAP_OUT;
  endproperty
  a_temp_after_three: assert property (p_temp_after_three) else $error("temp switch byte count wrong");

  property p_temp_return;
    (state == ST_TEMP_USER) && fetch && !user_rst_rise |=> (state == ST_MON) && !USER_MAP_OUT;
  endproperty
  a_temp_return: assert property (p_temp_return) else $error("temp switch did not return");

  property p_temp_fetch_mon;
    temp_return |=> DECODE_OUT.mon_sel && !DECODE_OUT.write_block;
  endproperty
  a_temp_fetch_mon: assert property (p_temp_fetch_mon) else $error("return fetch not from monitor");

  property p_rti_enter;
    (state == ST_PERM_WAIT) && fetch && BUS_DATA_IN == RET_INT_OPCODE |=> USER_MAP_OUT;
  endproperty
  a_rti_enter: assert property (p_rti_enter) else $error("return opcode did not enter user map");

  property p_user_reset;
    user_rst_rise |=> USER_MAP_OUT && USER_RESET_OUT && USER_RESET_MODE_OUT;
  endproperty
  a_user_reset: assert property (p_user_reset) else $error("user reset did not select user map");

  property p_bkpt_ignored;
    (state == ST_USER_RST) && swi_seen && !abort_held && !user_rst_rise |=> state == ST_USER_RST;
  endproperty
  a_bkpt_ignored: assert property (p_bkpt_ignored) else $error("breakpoint honoured after user reset");

  property p_swi_plain;
    (state == ST_USER) && swi_seen && !bkpt && !abort_held && !user_rst_rise |=> state == ST_USER ##0 USER_MAP_OUT;
  endproperty
  a_swi_plain: assert property (p_swi_plain) else $error("plain soft interrupt left user map");

  property p_stack_exit;
    (state == ST_STACK) && BUS_VALID_IN && BUS_WR_IN && cnt == 3'h4 && !user_rst_rise |=> !USER_MAP_OUT;
  endproperty
  a_stack_exit: assert property (p_stack_exit) else $error("monitor not entered after five pushes");

  property p_abort_force;
    (state == ST_USER) && abort_held && !swi_seen && !user_rst_rise |=>
      (state == ST_ABORT_FORCE) && FORCE_DATA_OE_OUT && FORCE_DATA_OUT == SOFT_INT_OPCODE;
  endproperty
  a_abort_force: assert property (p_abort_force) else $error("abort not forcing soft interrupt");

  property p_abort_mon;
    (state == ST_MON) && !TEMP_SWITCH_CMD_IN && !PERM_SWITCH_CMD_IN && !user_rst_rise |=>
      (state == ST_MON) && !FORCE_DATA_OE_OUT;
  endproperty
  a_abort_mon: assert property (p_abort_mon) else $error("monitor map disturbed");

  property p_wp;
    BUS_VALID_IN && BUS_WR_IN && (state == ST_USER) && user_addr >= USER_PROG_LO &&
      user_addr <= USER_PROG_HI |=> DECODE_OUT.write_block;
  endproperty
  a_wp: assert property (p_wp) else $error("program write not blocked");

  property p_temp_no_wp;
    BUS_VALID_IN && (state == ST_TEMP_USER) |=> !DECODE_OUT.write_block;
  endproperty
  a_temp_no_wp: assert property (p_temp_no_wp) else $error("temp access write blocked");

endmodule : mums_map_switch

/* tb/mums_core_model.sv */
`timescale 1ns/1ps
// Behavioural core: one bus cycle per call, launched on the falling edge
module mums_core_model
  import mums_pkg::*;
(
  input  wire logic         clk_in,
  input  wire mums_decode_t dec_in,
  input  wire mums_addr_t   maddr_in,
  output logic              valid_out,
  output mums_addr_t        addr_out,
  output logic              wr_out,
  output logic              fetch_out,
  output logic [7:0]        data_out
);
  mums_decode_t dec;
  mums_addr_t   maddr;

  // Idle bus at time zero
  initial begin
    valid_out = 1'b0;
    addr_out  = 13'h0000;
    wr_out    = 1'b0;
    fetch_out = 1'b0;
    data_out  = 8'h00;
  end

  // Hold across one rising edge; on release the controls drop and address and data are inverted so stale values never look valid
  task automatic cycle(input mums_addr_t a, input logic w, input logic f, input logic [7:0] d);
    @(negedge clk_in);
    valid_out = 1'b1;
    addr_out  = a;
    wr_out    = w;
    fetch_out = f;
    data_out  = d;
    @(negedge clk_in);
    dec       = dec_in;
    maddr     = maddr_in;
    valid_out = 1'b0;
    wr_out    = 1'b0;
    fetch_out = 1'b0;
    addr_out  = ~a;
    data_out  = ~d;
  endtask : cycle

  // Register bytes pushed downward from the stack top
  task automatic stack(input int n);
    for (int i = 0; i < n; i++) begin
      cycle(USER_RAM_HI - 13'(i), 1'b1, 1'b0, 8'hA5);
    end
  endtask : stack
endmodule : mums_core_model

/* tb/testbench.sv */
`timescale 1ns/1ps
// Self-checking bench for the map switch
module testbench;
  import mums_pkg::*;
  logic         clk, rst, temp_cmd, perm_cmd, bkpt_set, bkpt_clr, ureset_sw, abort_sw, map_2k;
  logic         valid, wr, fetch, user_map, force_oe, ureset_out, ureset_mode, bkpt_armed;
  logic [7:0]   data, force_data;
  mums_addr_t   addr, maddr;
  mums_decode_t dec;
  int           errors = 0;
  int           compares = 0;
  int           cycles = 0;

  always #4 clk = ~clk;

  mums_map_switch u_dut (
    .CLK_IN(clk), .RST_IN(rst), .BUS_VALID_IN(valid), .BUS_ADDR_IN(addr), .BUS_WR_IN(wr),
    .OPCODE_FETCH_CYCLE_IN(fetch), .BUS_DATA_IN(data), .TEMP_SWITCH_CMD_IN(temp_cmd),
    .PERM_SWITCH_CMD_IN(perm_cmd), .BKPT_SET_IN(bkpt_set), .BKPT_CLEAR_IN(bkpt_clr),
    .USER_RESET_SW_IN(ureset_sw), .ABORT_SW_IN(abort_sw), .MAP_2K_SEL_IN(map_2k),
    .USER_MAP_OUT(user_map), .DECODE_OUT(dec), .MAPPED_ADDR_OUT(maddr), .FORCE_DATA_OE_OUT(force_oe),
    .FORCE_DATA_OUT(force_data), .USER_RESET_OUT(ureset_out), .USER_RESET_MODE_OUT(ureset_mode),
    .BKPT_ARMED_OUT(bkpt_armed));

  mums_core_model u_core (
    .clk_in(clk), .dec_in(dec), .maddr_in(maddr), .valid_out(valid), .addr_out(addr),
    .wr_out(wr), .fetch_out(fetch), .data_out(data));

  task automatic conclude;
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Decode flags packed as valid,mon,io,ram,prog,block
  task automatic chk_dec(input logic [5:0] e, input mums_addr_t a);
    chk("decode", 16'(e), 16'(u_core.dec));
    chk("mapped", 16'(a), 16'(u_core.maddr));
  endtask : chk_dec

  // Enters user map through the return opcode
  task automatic go_user;
    perm_cmd = 1'b1;
    idle(1);
    perm_cmd = 1'b0;
    u_core.cycle(13'h1300, 1'b0, 1'b1, RET_INT_OPCODE);
    chk_dec(6'h30, 13'h0300);
    idle(2);
    chk("user_map", 16'h0001, 16'(user_map));
  endtask : go_user

  task automatic t_monitor;
    chk("user_map", 16'h0000, 16'(user_map));
    chk("bkpt_armed", 16'h0000, 16'(bkpt_armed));
    abort_sw = 1'b1;
    idle(4);
    u_core.cycle(13'h1100, 1'b0, 1'b1, SOFT_INT_OPCODE);
    chk_dec(6'h30, 13'h0100);
    idle(2);
    chk("force_oe", 16'h0000, 16'(force_oe));
    chk("user_map", 16'h0000, 16'(user_map));
    abort_sw = 1'b0;
    idle(4);
  endtask : t_monitor

  // Opcode and operands from monitor, one write in user, back on next fetch
  task automatic t_temp;
    temp_cmd = 1'b1;
    idle(1);
    temp_cmd = 1'b0;
    u_core.cycle(13'h0200, 1'b0, 1'b1, 8'hC7);
    u_core.cycle(13'h0201, 1'b0, 1'b0, 8'h01);
    u_core.cycle(13'h0202, 1'b0, 1'b0, 8'h00);
    chk_dec(6'h30, 13'h0202);
    idle(2);
    chk("user_map", 16'h0001, 16'(user_map));
    u_core.cycle(13'h1900, 1'b1, 1'b0, 8'h5A);
    chk_dec(6'h22, 13'h1900);
    u_core.cycle(13'h0203, 1'b0, 1'b1, 8'h9D);
    chk_dec(6'h30, 13'h0203);
    idle(2);
    chk("user_map", 16'h0000, 16'(user_map));
  endtask : t_temp

  task automatic t_user;
    go_user();
    u_core.cycle(13'h0050, 1'b1, 1'b0, 8'h11);
    chk_dec(6'h24, 13'h0050);
    u_core.cycle(13'h0100, 1'b1, 1'b0, 8'h22);
    chk_dec(6'h23, 13'h0100);
    u_core.cycle(13'h0400, 1'b0, 1'b1, SOFT_INT_OPCODE);
    idle(2);
    chk("user_map", 16'h0001, 16'(user_map));
    bkpt_set = 1'b1;
    idle(1);
    bkpt_set = 1'b0;
    idle(2);
    chk("bkpt_armed", 16'h0001, 16'(bkpt_armed));
    u_core.cycle(13'h0401, 1'b0, 1'b1, SOFT_INT_OPCODE);
    u_core.stack(4);
    idle(2);
    chk("user_map", 16'h0001, 16'(user_map));
    u_core.stack(1);
    idle(2);
    chk("user_map", 16'h0000, 16'(user_map));
    bkpt_clr = 1'b1;
    idle(1);
    bkpt_clr = 1'b0;
    idle(2);
    chk("bkpt_armed", 16'h0000, 16'(bkpt_armed));
  endtask : t_user

  task automatic t_abort;
    go_user();
    abort_sw = 1'b1;
    idle(5);
    chk("force_oe", 16'h0001, 16'(force_oe));
    chk("force_data", 16'h0083, 16'(force_data));
    u_core.cycle(13'h0500, 1'b0, 1'b1, SOFT_INT_OPCODE);
    abort_sw = 1'b0;
    idle(2);
    chk("force_oe", 16'h0000, 16'(force_oe));
    u_core.stack(5);
    idle(2);
    chk("user_map", 16'h0000, 16'(user_map));
  endtask : t_abort

  // Reset entry in 2K mode: vectors mirrored, breakpoints ignored
  task automatic t_ureset;
    ureset_sw = 1'b1;
    map_2k = 1'b1;
    idle(5);
    chk("user_reset", 16'h0001, 16'(ureset_out));
    chk("user_map", 16'h0001, 16'(user_map));
    chk("reset_mode", 16'h0001, 16'(ureset_mode));
    ureset_sw = 1'b0;
    idle(4);
    u_core.cycle(13'h1FF8, 1'b0, 1'b0, 8'h00);
    chk_dec(6'h22, 13'h07F8);
    u_core.cycle(13'h0805, 1'b0, 1'b0, 8'h00);
    chk_dec(6'h28, 13'h0005);
    bkpt_set = 1'b1;
    idle(1);
    bkpt_set = 1'b0;
    u_core.cycle(13'h0600, 1'b0, 1'b1, SOFT_INT_OPCODE);
    idle(2);
    chk("user_map", 16'h0001, 16'(user_map));
  endtask : t_ureset

  // Reset in mid-run drops user mode and the armed breakpoint
  task automatic t_power;
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    idle(1);
    chk("user_map", 16'h0000, 16'(user_map));
    chk("bkpt_armed", 16'h0000, 16'(bkpt_armed));
    chk("reset_mode", 16'h0000, 16'(ureset_mode));
  endtask : t_power

  // Hang guard, well above the roughly 115 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    {clk, temp_cmd, perm_cmd, bkpt_set, bkpt_clr, ureset_sw, abort_sw} = 7'h00;
    rst = 1'b1;
    map_2k = 1'b0;
    idle(6);
    rst = 1'b0;
    t_monitor();
    t_temp();
    t_user();
    t_abort();
    t_ureset();
    t_power();
    conclude();
  end
endmodule : testbench
